/* design/drp_pkg.sv */
// package of constants and carriers for the dma register programming block
// Summary of operation
// (R1) byte writes load base and current together
// (R2) command register, cleared by reset or clear
// (R3) current address steps by one per transfer, up or down
// (R4) address hold freezes channel 0 in mem-mem
// (R5) count wraps to ffff raises terminal count
// (R6) autoinit restores after end; else count ffff after terminal count, count kept after external end
// (R7) mask bit sets on end without autoinit
// (R8) reset sets all masks; software edits them
// (R9) mask read: bits 0-3 masks, 4-7 ones
// (R10) mode write picks channel; read lows ones
// (R11) software request bits bypass mask, clear reset
// (R12) request read: bits 0-3, upper bits ones
// (R13) status low bits set on end, read clears
// (R14) status high bits show raw requests
// (R15) temporary register keeps last moved byte
// (R16) host access only when grant low settled
// (R17) host disables controller before reprogramming
// (R18) commands decoded from access, data ignored
// (R19) clear command resets byte pointer
// (R20) set command makes high byte first
// (R21) master clear acts as hardware reset; code keeps channel addresses, counts and modes, which reset clears
// (R22) clear mask command unmasks every channel
// (R23) mode read counter cleared, advances per read
// (R24) hold request raised; drive after grant
// (R25) pointer starts low, toggles per byte
// (R26) decode follows the command code table
package drp_pkg;
	localparam int DRP_NCH = 4;
	localparam logic [3:0] DRP_CMD_STAT = 4'h8;
	localparam logic [3:0] DRP_REQ = 4'h9;
	localparam logic [3:0] DRP_MASK1 = 4'hA;
	localparam logic [3:0] DRP_MODE = 4'hB;
	localparam logic [3:0] DRP_PTR = 4'hC;
	localparam logic [3:0] DRP_TEMP_MCLR = 4'hD;
	localparam logic [3:0] DRP_MCNT_CLRM = 4'hE;
	localparam logic [3:0] DRP_MASKALL = 4'hF;
	localparam int DRP_CMD_MEM2MEM = 0;
	localparam int DRP_CMD_AHOLD = 1;
	localparam int DRP_CMD_DISABLE = 2;
	localparam int DRP_MODE_AUTO = 4;
	localparam int DRP_MODE_DOWN = 5;
	localparam int DRP_SETBIT = 2;
	localparam logic [15:0] DRP_CNT_END = 16'hFFFF;
	localparam logic [3:0] DRP_UPPER_ONES = 4'hF;
	localparam logic [1:0] DRP_LOW_ONES = 2'h3;
	typedef struct packed {
		logic [15:0] base_addr;
		logic [15:0] base_cnt;
		logic [15:0] cur_addr;
		logic [15:0] cur_cnt;
		logic [5:0] mode;
	} drp_chan_t;
	typedef struct packed {
		drp_chan_t [DRP_NCH-1:0] ch;
		logic [7:0] cmd;
		logic [3:0] tc_flags;
		logic [3:0] req_flags;
		logic [3:0] soft_req;
		logic [3:0] mask;
		logic [7:0] temp;
		logic hi_byte;
		logic [1:0] mode_cnt;
		logic [2:0] grant_sync;
		logic grant_ok;
		logic [2:0] rd_sync;
		logic [2:0] wr_sync;
		logic [7:0] rdata;
		logic hold_req;
	} drp_state_t;
	typedef struct packed {
		logic xfer_done;
		logic [1:0] xfer_ch;
		logic ext_end;
		logic [1:0] end_ch;
		logic temp_load;
		logic [7:0] temp_byte;
	} drp_engine_t;
endpackage : drp_pkg

/* design/drp_regs.sv */
// register file and command decoder of the four channel dma controller
`timescale 1ns/100ps
module drp_regs import drp_pkg::*; (
	input wire logic clk, // 20 MHz clock
	input wire logic nrst, // async reset, active low
	input wire logic chip_sel_n, // chip select, active low
	input wire logic io_read_strobe_n, // host read strobe, active low
	input wire logic io_write_strobe_n, // host write strobe, active low
	input wire logic [3:0] addr, // low address bits
	input wire logic [7:0] wdata, // host write data
	output logic [7:0] rdata, // host read data, registered
	input wire logic hold_grant, // hold acknowledge from host
	input wire logic [3:0] channel_request_in, // peripheral requests
	input wire drp_engine_t engine, // transfer events from engine
	output logic hold_request_out, // hold request to host
	output logic [3:0] req_pending, // unmasked and software requests
	output logic ctrl_disabled, // command bit 2
	output logic [7:0] command_q, // command register contents
	output logic bus_drive_ok // engine may drive buses
);
	drp_state_t s_r, s_nxt;
	logic rd_ev, wr_ev;
	logic [3:0] ext_req;

	function automatic logic [3:0] drp_onehot(input logic [1:0] c);
		drp_onehot = 4'h1 << c;
	endfunction : drp_onehot

	function automatic logic [15:0] drp_put(input logic [15:0] v,
		input logic hi, input logic [7:0] b);
		drp_put = hi ? {b, v[7:0]} : {v[15:8], b};
	endfunction : drp_put

	// strobes from pins: event on the agreed edge of stages two and three
	assign rd_ev = s_r.rd_sync[1] & ~s_r.rd_sync[2] & ~chip_sel_n
		& s_r.grant_ok; // R16
	assign wr_ev = s_r.wr_sync[1] & ~s_r.wr_sync[2] & ~chip_sel_n
		& s_r.grant_ok; // R16
	assign ext_req = channel_request_in;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_sync = {s_r.rd_sync[1:0], ~io_read_strobe_n};
		s_nxt.wr_sync = {s_r.wr_sync[1:0], ~io_write_strobe_n};
		s_nxt.grant_sync = {s_r.grant_sync[1:0], hold_grant};
		// access allowed one edge after grant agreed low
		s_nxt.grant_ok = ~s_r.grant_sync[1] & ~s_r.grant_sync[2]; // R16
		s_nxt.req_flags = ext_req; // R14
		// uses the latched request bits, so hold follows req_pending by one
		s_nxt.hold_req = (|((s_r.req_flags & ~s_r.mask) | s_r.soft_req))
			& ~s_r.cmd[DRP_CMD_DISABLE]; // R24
		// transfer side effects
		if (engine.xfer_done) begin
			for (int i = 0; i < DRP_NCH; i++) begin
				if (engine.xfer_ch == 2'(i)) begin
					if (!(i == 0 && s_r.cmd[DRP_CMD_MEM2MEM]
						&& s_r.cmd[DRP_CMD_AHOLD])) begin // R4
						s_nxt.ch[i].cur_addr =
							s_r.ch[i].mode[DRP_MODE_DOWN] ?
							s_r.ch[i].cur_addr - 16'h0001 :
							s_r.ch[i].cur_addr + 16'h0001; // R3
					end
					s_nxt.ch[i].cur_cnt = s_r.ch[i].cur_cnt - 16'h0001; // R5
					if (s_r.ch[i].cur_cnt == 16'h0000) begin // R5
						s_nxt.tc_flags[i] = 1'b1; // R13
						if (s_r.ch[i].mode[DRP_MODE_AUTO]) begin // R6
							s_nxt.ch[i].cur_addr = s_r.ch[i].base_addr;
							s_nxt.ch[i].cur_cnt = s_r.ch[i].base_cnt;
						end else begin
							s_nxt.mask[i] = 1'b1; // R7
						end
						s_nxt.soft_req[i] = 1'b0;
					end
				end
			end
		end
		if (engine.ext_end) begin
			for (int i = 0; i < DRP_NCH; i++) begin
				if (engine.end_ch == 2'(i)) begin
					s_nxt.tc_flags[i] = 1'b1; // R13
					if (s_r.ch[i].mode[DRP_MODE_AUTO]) begin // R6
						s_nxt.ch[i].cur_addr = s_r.ch[i].base_addr;
						s_nxt.ch[i].cur_cnt = s_r.ch[i].base_cnt;
					end else begin
						s_nxt.mask[i] = 1'b1; // R7
					end
				end
			end
		end
		if (engine.temp_load)
			s_nxt.temp = engine.temp_byte; // R15
		// host reads
		if (rd_ev) begin // R18
			if (!addr[3]) begin
				for (int i = 0; i < DRP_NCH; i++) begin
					if (addr[2:1] == 2'(i)) begin
						s_nxt.rdata = addr[0] ?
							(s_r.hi_byte ? s_r.ch[i].cur_cnt[15:8]
								: s_r.ch[i].cur_cnt[7:0]) :
							(s_r.hi_byte ? s_r.ch[i].cur_addr[15:8]
								: s_r.ch[i].cur_addr[7:0]); // R1
					end
				end
				s_nxt.hi_byte = ~s_r.hi_byte; // R25
			end else begin
				unique case (addr) // R26
				DRP_CMD_STAT: begin
					s_nxt.rdata = {s_r.req_flags, s_r.tc_flags};
					// a flag set in this cycle survives the read
					s_nxt.tc_flags = s_nxt.tc_flags & ~s_r.tc_flags; // R13
				end
				DRP_REQ: s_nxt.rdata = {DRP_UPPER_ONES, s_r.soft_req}; // R12
				DRP_MASK1: s_nxt.rdata = s_r.cmd;
				DRP_MODE: begin
					s_nxt.rdata = {s_r.ch[s_r.mode_cnt].mode,
						DRP_LOW_ONES}; // R10
					s_nxt.mode_cnt = s_r.mode_cnt + 2'h1; // R23
				end
				DRP_PTR: s_nxt.hi_byte = 1'b1; // R20
				DRP_TEMP_MCLR: s_nxt.rdata = s_r.temp; // R15
				DRP_MCNT_CLRM: s_nxt.mode_cnt = 2'h0; // R23
				DRP_MASKALL: s_nxt.rdata = {DRP_UPPER_ONES, s_r.mask}; // R9
				default: s_nxt.rdata = s_r.rdata;
				endcase
			end
		end
		// host writes
		if (wr_ev) begin // R18
			if (!addr[3]) begin
				for (int i = 0; i < DRP_NCH; i++) begin
					if (addr[2:1] == 2'(i)) begin
						if (addr[0]) begin
							s_nxt.ch[i].base_cnt =
								drp_put(s_r.ch[i].base_cnt, s_r.hi_byte, wdata);
							s_nxt.ch[i].cur_cnt =
								drp_put(s_r.ch[i].cur_cnt, s_r.hi_byte, wdata); // R1
						end else begin
							s_nxt.ch[i].base_addr =
								drp_put(s_r.ch[i].base_addr, s_r.hi_byte, wdata);
							s_nxt.ch[i].cur_addr =
								drp_put(s_r.ch[i].cur_addr, s_r.hi_byte, wdata); // R1
						end
					end
				end
				s_nxt.hi_byte = ~s_r.hi_byte; // R25
			end else begin
				unique case (addr) // R26
				DRP_CMD_STAT: s_nxt.cmd = wdata; // R2
				DRP_REQ: begin
					if (wdata[DRP_SETBIT])
						s_nxt.soft_req = s_nxt.soft_req | drp_onehot(wdata[1:0]);
					else
						s_nxt.soft_req = s_r.soft_req & ~drp_onehot(wdata[1:0]); // R11
				end
				DRP_MASK1: begin
					if (wdata[DRP_SETBIT])
						s_nxt.mask = s_nxt.mask | drp_onehot(wdata[1:0]);
					else
						s_nxt.mask = s_r.mask & ~drp_onehot(wdata[1:0]); // R8
				end
				DRP_MODE: begin
					for (int i = 0; i < DRP_NCH; i++) begin
						if (wdata[1:0] == 2'(i))
							s_nxt.ch[i].mode = wdata[7:2]; // R10
					end
				end
				DRP_PTR: s_nxt.hi_byte = 1'b0; // R19
				DRP_TEMP_MCLR: begin // R21
					s_nxt.cmd = 8'h00;
					s_nxt.tc_flags = 4'h0;
					s_nxt.req_flags = 4'h0;
					s_nxt.soft_req = 4'h0;
					s_nxt.temp = 8'h00;
					s_nxt.hi_byte = 1'b0;
					s_nxt.mode_cnt = 2'h0;
					s_nxt.mask = 4'hF;
				end
				DRP_MCNT_CLRM: s_nxt.mask = 4'h0; // R22
				DRP_MASKALL: s_nxt.mask = wdata[3:0]; // R8
				default: s_nxt.cmd = s_r.cmd;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0; // R2
			s_r.mask <= 4'hF; // R8
			s_r.grant_sync <= 3'h7;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign hold_request_out = s_r.hold_req; // R24
	assign req_pending = (s_r.req_flags & ~s_r.mask) | s_r.soft_req; // R11
	assign ctrl_disabled = s_r.cmd[DRP_CMD_DISABLE]; // R17
	assign command_q = s_r.cmd;
	assign bus_drive_ok = s_r.hold_req & s_r.grant_sync[1]
		& s_r.grant_sync[2]; // R24
endmodule : drp_regs

/* dv/drp_regs_sva.sv */
// assertions on the ports of the register block
`timescale 1ns/100ps
module drp_regs_sva import drp_pkg::*; (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire logic io_read_strobe_n, // read strobe
	input wire logic io_write_strobe_n, // write strobe
	input wire logic hold_grant, // hold grant
	input wire logic [7:0] rdata, // read data
	input wire logic hold_request_out, // hold request
	input wire logic [3:0] req_pending, // requests
	input wire logic ctrl_disabled, // disabled
	input wire logic [7:0] command_q, // command
	input wire logic bus_drive_ok // drive ok
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_drive_hold: assert property (bus_drive_ok |-> hold_request_out)
		else $error("drive without hold");
	a_drive_grant: assert property ((!hold_grant)[*5] |-> !bus_drive_ok)
		else $error("drive without grant");
	a_grant_drive: assert property (hold_grant[*5] ##0 hold_request_out
		|-> bus_drive_ok)
		else $error("grant not followed");
	a_disable_bit: assert property
		(ctrl_disabled == command_q[DRP_CMD_DISABLE])
		else $error("disable bit mismatch");
	a_hold_cause: assert property
		(hold_request_out == $past(|req_pending && !ctrl_disabled))
		else $error("hold request wrong");
	a_cmd_quiet: assert property
		(io_write_strobe_n[*5] |-> $stable(command_q))
		else $error("command changed");
	a_rdata_holds: assert property
		(io_read_strobe_n[*5] |-> $stable(rdata))
		else $error("read data changed");
	a_grant_refuse: assert property
		(hold_grant[*6] |-> $stable(command_q))
		else $error("access during grant");
	c_drive: cover property (bus_drive_ok);
	c_disabled: cover property (ctrl_disabled);
	c_hold: cover property ($rose(hold_request_out));
endmodule : drp_regs_sva

bind drp_regs drp_regs_sva u_sva (.clk, .nrst, .io_read_strobe_n,
	.io_write_strobe_n, .hold_grant, .rdata, .hold_request_out,
	.req_pending, .ctrl_disabled, .command_q, .bus_drive_ok);

/* dv/drp_host_model.sv */
// host model that grants the buses after a hold request
`timescale 1ns/100ps
module drp_host_model #(parameter int LAT = 3) (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire logic hold_request_out, // hold request
	output logic hold_grant // hold grant
);
	int cnt;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			hold_grant <= 1'b0;
		end else begin
			cnt <= hold_request_out ? cnt + 1 : 0;
			hold_grant <= hold_request_out && cnt >= LAT;
		end
	end
endmodule : drp_host_model

/* dv/tb_top.sv */
// self-checking bench for the register block
`timescale 1ns/100ps
module tb_top;
	import drp_pkg::*;
	logic clk, nrst, chip_sel_n, io_read_strobe_n, io_write_strobe_n;
	logic hold_grant, hold_request_out, ctrl_disabled, bus_drive_ok;
	logic [3:0] addr, channel_request_in, req_pending;
	logic [7:0] wdata, rdata, command_q;
	drp_engine_t engine;
	int n_fail = 0;
	int num_checks = 0;
	drp_regs u_dut (.clk, .nrst, .chip_sel_n, .io_read_strobe_n,
		.io_write_strobe_n, .addr, .wdata, .rdata, .hold_grant,
		.channel_request_in, .engine, .hold_request_out, .req_pending,
		.ctrl_disabled, .command_q, .bus_drive_ok);
	drp_host_model #(.LAT(3)) u_host (.clk, .nrst, .hold_request_out,
		.hold_grant);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// r: 0 write, 1 read and compare with d, 2 read only
	task automatic acc(input int r, input logic [3:0] a, input logic [7:0] d);
		for (int k = 0; k < 400 && hold_grant !== 1'b0; k++) @(posedge clk);
		repeat (3) @(posedge clk);
		#5 {chip_sel_n, io_read_strobe_n, io_write_strobe_n, addr, wdata} =
			{1'b0, r == 0, r != 0, a, d};
		repeat (5) @(posedge clk);
		#5 {chip_sel_n, io_read_strobe_n, io_write_strobe_n} = 3'h7;
		if (r == 1)
			chk(rdata, d);
	endtask : acc
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#1000000;
		n_fail++;
		stop_test();
	end
	initial begin
		{nrst, chip_sel_n, io_read_strobe_n, io_write_strobe_n} = 4'h7;
		nrst = 1'b0;
		{addr, wdata, channel_request_in} = '0;
		engine = '0;
		repeat (2) @(posedge clk);
		#5 nrst = 1'b1;
		acc(1, 4'hF, 8'hFF);
		acc(1, 4'h8, 8'h00);
		acc(1, 4'h9, 8'hF0);
		acc(0, 4'h8, 8'h04);
		acc(1, 4'hA, 8'h04);
		acc(0, 4'hC, 8'h00);
		acc(0, 4'h6, 8'h10);
		acc(0, 4'h6, 8'h00);
		acc(0, 4'h7, 8'h00);
		acc(0, 4'h7, 8'h00);
		acc(0, 4'hB, 8'h03);
		acc(0, 4'hB, 8'hF1);
		acc(0, 4'h9, 8'h07);
		acc(1, 4'h9, 8'hF8);
		acc(1, 4'h6, 8'h10);
		acc(2, 4'hC, 8'h00);
		acc(1, 4'h6, 8'h00);
		acc(2, 4'hE, 8'h00);
		acc(2, 4'hB, 8'h00);
		acc(1, 4'hB, 8'hF3);
		acc(0, 4'hF, 8'h00);
		acc(0, 4'hA, 8'h06);
		acc(1, 4'hF, 8'hF4);
		acc(0, 4'hE, 8'h00);
		acc(1, 4'hF, 8'hF0);
		acc(0, 4'h8, 8'h00);
		for (int k = 0; k < 400 && bus_drive_ok !== 1'b1; k++) @(posedge clk);
		chk({7'h00, bus_drive_ok}, 8'h01);
		@(posedge clk) #5 engine = '{1'b1, 2'h3, 1'b1, 2'h0, 1'b1, 8'h5A};
		@(posedge clk) #5 engine = '0;
		acc(1, 4'h8, 8'h09);
		acc(1, 4'h8, 8'h00);
		acc(0, 4'hC, 8'h00);
		acc(1, 4'h7, 8'hFF);
		acc(1, 4'h7, 8'hFF);
		acc(1, 4'h6, 8'h11);
		acc(1, 4'hF, 8'hF9);
		acc(1, 4'hD, 8'h5A);
		acc(0, 4'hD, 8'hAA);
		acc(1, 4'hF, 8'hFF);
		acc(1, 4'hA, 8'h00);
		acc(1, 4'hD, 8'h00);
		acc(1, 4'h6, 8'h11);
		channel_request_in = 4'h2;
		acc(1, 4'h8, 8'h20);
		stop_test();
	end
endmodule : tb_top
